// [shared/ssr_pkg.sv]
package ssr_pkg;
	localparam int BYTE_BITS = 8;
	localparam int STAT_NRDY_BIT = 7;
	localparam int STAT_STATE_HI = 6;
	localparam int STAT_STATE_LO = 4;
	localparam int STAT_COUNT_HI = 3;
	localparam logic [6:0] COUNT_SAT = 7'h0f;
	localparam int HDR_RW_BIT = 7;
	localparam int HDR_BURST_BIT = 6;
	localparam logic [5:0] STROBE_FIRST = 6'h30;
	localparam logic [5:0] STROBE_LAST = 6'h3d;
	localparam logic [5:0] FIFO_ADDR = 6'h3f;
	localparam logic [7:0] HDR_TX_SINGLE = 8'h3f;
	localparam logic [7:0] HDR_TX_BURST = 8'h7f;
	localparam logic [7:0] HDR_RX_SINGLE = 8'hbf;
	localparam logic [7:0] HDR_RX_BURST = 8'hff;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_RX = 3'h1,
		ST_TX = 3'h2,
		ST_FAST_TX_READY = 3'h3,
		ST_CALIBRATE = 3'h4,
		ST_SETTLING = 3'h5,
		ST_RX_OVERFLOW = 3'h6,
		ST_TX_UNDERFLOW = 3'h7
	} ssr_state_t;
	localparam logic [7:0] REG_TXN = 8'h00;
	localparam logic [7:0] REG_RXD = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;
	localparam logic [7:0] REG_IRQ_STAT = 8'h0c;
	localparam logic [7:0] REG_IRQ_CLR = 8'h10;
	localparam logic [7:0] REG_IRQ_EN = 8'h14;
	localparam int TXN_KEEP_BIT = 8;
	localparam int TXN_STATUS_BIT = 9;
	localparam int STAT_BUSY_BIT = 8;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_OVF = 1;
	localparam int IRQ_UNF = 2;
	localparam int IRQ_W = 3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int CLK_PERIOD_NS = 8;
	localparam int SCLK_PERIOD_NS = 128;
	localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
endpackage

// [shared/ssr_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface ssr_if;
	logic chip_select_n;
	logic sclk;
	logic si;
	logic so;
	logic so_oe;
	logic so_line;
	// pull-up keeps the line high while the device leaves it undriven
	assign so_line = so_oe ? so : 1'b1;
	modport device (
		input chip_select_n,
		input sclk,
		input si,
		output so,
		output so_oe
	);
	modport host (
		output chip_select_n,
		output sclk,
		output si,
		input so_line
	);
endinterface
`default_nettype wire

// [src/ssr_device.sv]
`timescale 1ns/1ps
`default_nettype none
module ssr_device
	import ssr_pkg::*;
(
	input wire logic aclk, // system clock
	input wire logic aresetn, // sync reset, active low
	ssr_if.device link, // serial pins
	input wire logic supply_ok, // core supply stable
	input wire logic crystal_oscillator_ok, // crystal oscillator stable
	input wire logic [2:0] main_state, // main state code
	input wire logic [6:0] rx_count, // bytes in receive fifo
	input wire logic [6:0] tx_free, // bytes free in transmit fifo
	input wire logic [7:0] rd_data, // read data for acc_addr
	output logic [5:0] acc_addr, // address of current access
	output logic wr_valid, // pulse: write wr_data
	output logic [7:0] wr_data, // write data
	output logic rd_req, // pulse: fetch rd_data
	output logic strobe_valid, // pulse: command strobe
	output logic chip_not_ready, // ready flag, active high = not ready
	output logic others_powered_down // idle power state
);

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers

logic cs_s1;
logic cs_s2;
logic ck_s1;
logic ck_s2;
logic ck_d;
logic si_s1;
logic si_s2;

always_ff @(posedge aclk) begin
	if (!aresetn) begin
		cs_s1 <= 1'b1;
		cs_s2 <= 1'b1;
		ck_s1 <= 1'b0;
		ck_s2 <= 1'b0;
		ck_d <= 1'b0;
		si_s1 <= 1'b0;
		si_s2 <= 1'b0;
	end else begin
		cs_s1 <= link.chip_select_n;
		cs_s2 <= cs_s1;
		ck_s1 <= link.sclk;
		ck_s2 <= ck_s1;
		ck_d <= ck_s2;
		si_s1 <= link.si;
		si_s2 <= si_s1;
	end
end

logic sel;
logic rise;
logic fall;
assign sel = ~cs_s2;
assign rise = sel & ck_s2 & ~ck_d;
assign fall = sel & ~ck_s2 & ck_d;

////////////////////////////////////////////////////////////////////////////////
// status byte

logic rw;
logic rw_live;
logic in_hdr;
logic [2:0] bitcnt;
logic [6:0] count_sel;
logic [3:0] count_sat;
logic [7:0] status_live;

always_ff @(posedge aclk) begin
	if (!aresetn) begin
		chip_not_ready <= 1'b1;
	end else begin
		chip_not_ready <= ~(supply_ok & crystal_oscillator_ok);
	end
end

// idle leaves only the oscillator and digital core up
always_ff @(posedge aclk) begin
	if (!aresetn) begin
		others_powered_down <= 1'b1;
	end else begin
		others_powered_down <= (main_state == ST_IDLE);
	end
end

// the rw bit of the header in flight picks the count once its first bit is in
always_comb begin
	count_sel = (in_hdr && bitcnt != 3'h0) ? (rw_live ? rx_count : tx_free)
		: (rw ? rx_count : tx_free);
	count_sat = (count_sel > COUNT_SAT) ? COUNT_SAT[3:0] : count_sel[3:0];
	status_live = {chip_not_ready, main_state, count_sat};
end

////////////////////////////////////////////////////////////////////////////////
// byte framing

logic [6:0] in_sh;
logic [7:0] in_byte;
logic byte_done;
logic burst;
logic [5:0] addr;
logic is_strobe;
assign in_byte = {in_sh, si_s2};
assign byte_done = rise && bitcnt == 3'h7;
assign is_strobe = !in_byte[HDR_RW_BIT] && !in_byte[HDR_BURST_BIT]
	&& in_byte[5:0] >= STROBE_FIRST && in_byte[5:0] <= STROBE_LAST;

always_ff @(posedge aclk) begin
	if (!aresetn) begin
		bitcnt <= 3'h0;
		in_sh <= 7'h00;
		rw_live <= 1'b0;
	end else if (!sel) begin
		bitcnt <= 3'h0;
	end else if (rise) begin
		bitcnt <= bitcnt + 3'h1;
		in_sh <= in_byte[6:0];
		if (bitcnt == 3'h0) begin
			rw_live <= si_s2;
		end
	end
end

// header decode and the burst address counter
always_ff @(posedge aclk) begin
	if (!aresetn) begin
		in_hdr <= 1'b1;
		rw <= 1'b0;
		burst <= 1'b0;
		addr <= 6'h00;
	end else if (!sel) begin
		in_hdr <= 1'b1;
	end else if (byte_done) begin
		if (in_hdr) begin
			rw <= in_byte[HDR_RW_BIT];
			burst <= in_byte[HDR_BURST_BIT];
			addr <= in_byte[5:0];
			in_hdr <= is_strobe;
		end else if (burst) begin
			if (addr != FIFO_ADDR) begin
				addr <= addr + 6'h01;
			end
			// fifo address stays put for the whole run
		end else begin
			in_hdr <= 1'b1;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// user side strobes

logic [5:0] next_addr;
assign next_addr = (addr == FIFO_ADDR) ? addr : addr + 6'h01;

always_ff @(posedge aclk) begin
	if (!aresetn) begin
		wr_valid <= 1'b0;
		rd_req <= 1'b0;
		strobe_valid <= 1'b0;
		acc_addr <= 6'h00;
		wr_data <= 8'h00;
	end else begin
		wr_valid <= 1'b0;
		rd_req <= 1'b0;
		strobe_valid <= 1'b0;
		if (byte_done && in_hdr) begin
			acc_addr <= in_byte[5:0];
			strobe_valid <= is_strobe;
			rd_req <= in_byte[HDR_RW_BIT];
		end else if (byte_done) begin
			if (!rw) begin
				wr_valid <= 1'b1;
				wr_data <= in_byte;
				acc_addr <= addr;
			end else if (burst) begin
				rd_req <= 1'b1;
				acc_addr <= next_addr;
			end
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// serial output

logic send_status;
logic [7:0] rd_byte;
logic [7:0] out_byte;
assign send_status = in_hdr | ~rw;
assign out_byte = send_status ? status_live : rd_byte;

always_ff @(posedge aclk) begin
	if (!aresetn) begin
		rd_byte <= 8'h00;
	end else if (bitcnt == 3'h0) begin
		rd_byte <= rd_data;
	end
end

// ahead of a status byte bit 7 follows the live flag so a waiting host sees it fall
always_ff @(posedge aclk) begin
	if (!aresetn) begin
		link.so <= 1'b1;
		link.so_oe <= 1'b0;
	end else begin
		link.so_oe <= sel;
		// the last bit stands through the high phase, since the host samples late in it
		if (bitcnt == 3'h0 && !ck_s2) begin
			link.so <= send_status ? status_live[STAT_NRDY_BIT] : rd_data[7];
		end else if (fall) begin
			link.so <= out_byte[3'h7 - bitcnt];
		end
	end
end

endmodule
`default_nettype wire

// [src/ssr_host.sv]
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ssr_host
	import ssr_pkg::*;
#(
	parameter int HALF_CYC = SCLK_HALF_CYC
) (
	input wire logic aclk, // system clock
	input wire logic aresetn, // sync reset, active low
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // byte enables
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	ssr_if.host link, // serial pins
	output logic irq // level interrupt
);

typedef enum logic [2:0] {
	H_IDLE = 3'h0,
	H_WAIT = 3'h1,
	H_LOW = 3'h3,
	H_HIGH = 3'h2,
	H_FIN = 3'h6
} ssr_hstate_t;

ssr_hstate_t hst;
logic so_s1;
logic so_s2;
logic [3:0] cnt;
logic [2:0] bits;
logic [7:0] tx_sh;
logic [7:0] rx_sh;
logic [7:0] rxd;
logic [7:0] chip_stat;
logic keep;
logic is_status;
logic [IRQ_W-1:0] irq_stat;
logic [IRQ_W-1:0] irq_en;
logic [IRQ_W-1:0] ev;
logic [7:0] aw_addr;
logic [31:0] w_data;
logic aw_held;
logic w_held;
logic w_strb0;
logic do_write;
logic start;

////////////////////////////////////////////////////////////////////////////////
// axi4-lite slave

assign s_axi_awready = !aw_held && !s_axi_bvalid;
assign s_axi_wready = !w_held && !s_axi_bvalid;
assign s_axi_arready = !s_axi_rvalid;
assign do_write = aw_held && w_held && !s_axi_bvalid;
assign start = do_write && aw_addr == REG_TXN && hst == H_IDLE && w_strb0;

always_ff @(posedge aclk) begin
	if (!aresetn) begin
		aw_held <= 1'b0;
		w_held <= 1'b0;
		aw_addr <= 8'h00;
		w_data <= 32'h0;
		w_strb0 <= 1'b0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= RESP_OKAY;
	end else begin
		if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			// strobes only qualify the beat they came with
			w_strb0 <= s_axi_wstrb[0];
		end
		if (do_write) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			s_axi_bvalid <= 1'b1;
			// a transfer start while busy is refused
			s_axi_bresp <= (start || aw_addr == REG_IRQ_CLR || aw_addr == REG_IRQ_EN)
				? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end
end

always_ff @(posedge aclk) begin
	if (!aresetn) begin
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h0;
		s_axi_rresp <= RESP_OKAY;
	end else if (s_axi_arvalid && s_axi_arready) begin
		s_axi_rvalid <= 1'b1;
		s_axi_rresp <= RESP_OKAY;
		unique case (s_axi_araddr)
			REG_RXD: s_axi_rdata <= {24'h0, rxd};
			REG_STAT: s_axi_rdata <= {23'h0, hst != H_IDLE, chip_stat};
			REG_IRQ_STAT: s_axi_rdata <= {29'h0, irq_stat};
			REG_IRQ_EN: s_axi_rdata <= {29'h0, irq_en};
			default: begin
				s_axi_rdata <= 32'h0;
				s_axi_rresp <= RESP_SLVERR;
			end
		endcase
	end else if (s_axi_rready) begin
		s_axi_rvalid <= 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////////////
// interrupts: set wins over clear

always_ff @(posedge aclk) begin
	if (!aresetn) begin
		irq_stat <= '0;
		irq_en <= '0;
	end else begin
		if (do_write && aw_addr == REG_IRQ_EN) begin
			irq_en <= w_data[IRQ_W-1:0];
		end
		if (do_write && aw_addr == REG_IRQ_CLR) begin
			irq_stat <= (irq_stat & ~w_data[IRQ_W-1:0]) | ev;
		end else begin
			irq_stat <= irq_stat | ev;
		end
	end
end

assign irq = |(irq_stat & irq_en);

////////////////////////////////////////////////////////////////////////////////
// serial engine

always_ff @(posedge aclk) begin
	if (!aresetn) begin
		so_s1 <= 1'b1;
		so_s2 <= 1'b1;
	end else begin
		so_s1 <= link.so_line;
		so_s2 <= so_s1;
	end
end

always_comb begin
	ev = '0;
	if (hst == H_FIN) begin
		ev[IRQ_DONE] = 1'b1;
		ev[IRQ_OVF] = is_status && rx_sh[6:4] == ST_RX_OVERFLOW;
		ev[IRQ_UNF] = is_status && rx_sh[6:4] == ST_TX_UNDERFLOW;
	end
end

always_ff @(posedge aclk) begin
	if (!aresetn) begin
		hst <= H_IDLE;
		cnt <= 4'h0;
		bits <= 3'h0;
		tx_sh <= 8'h00;
		rx_sh <= 8'h00;
		keep <= 1'b0;
		is_status <= 1'b0;
		link.chip_select_n <= 1'b1;
		link.sclk <= 1'b0;
		link.si <= 1'b0;
	end else begin
		unique case (hst)
			H_IDLE: begin
				cnt <= 4'h0;
				bits <= 3'h0;
				if (start) begin
					tx_sh <= w_data[7:0];
					keep <= w_data[TXN_KEEP_BIT];
					is_status <= w_data[TXN_STATUS_BIT];
					link.si <= w_data[7];
					link.chip_select_n <= 1'b0;
					hst <= link.chip_select_n ? H_WAIT : H_LOW;
				end
			end
			H_WAIT: begin
				// skip a stale low left over from the previous frame
				if (cnt != HALF_CYC[3:0]) begin
					cnt <= cnt + 4'h1;
				end else if (!so_s2) begin
					cnt <= 4'h0;
					hst <= H_LOW;
				end
			end
			H_LOW: begin
				cnt <= cnt + 4'h1;
				if (cnt == HALF_CYC[3:0] - 4'h1) begin
					cnt <= 4'h0;
					link.sclk <= 1'b1;
					hst <= H_HIGH;
				end
			end
			H_HIGH: begin
				cnt <= cnt + 4'h1;
				if (cnt == HALF_CYC[3:0] - 4'h1) begin
					cnt <= 4'h0;
					rx_sh <= {rx_sh[6:0], so_s2};
					link.sclk <= 1'b0;
					tx_sh <= {tx_sh[6:0], 1'b0};
					link.si <= tx_sh[6];
					bits <= bits + 3'h1;
					hst <= (bits == 3'h7) ? H_FIN : H_LOW;
				end
			end
			H_FIN: begin
				link.chip_select_n <= !keep;
				hst <= H_IDLE;
			end
			default: hst <= H_IDLE;
		endcase
	end
end

always_ff @(posedge aclk) begin
	if (!aresetn) begin
		rxd <= 8'h00;
		chip_stat <= 8'hff;
	end else if (hst == H_FIN) begin
		rxd <= rx_sh;
		if (is_status) begin
			chip_stat <= rx_sh;
		end
	end
end

endmodule
`default_nettype wire

// [test/ssr_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module ssr_checker (
	input wire logic aclk, // system clock
	input wire logic aresetn, // sync reset, active low
	input wire logic chip_select_n, // select from host
	input wire logic sclk, // serial clock from host
	input wire logic si, // host to device data
	input wire logic so, // device data out
	input wire logic so_oe, // device drives so
	input wire logic so_line // resolved serial output
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic sclk_q;
	logic first;
	logic [5:0] edges;
	always_ff @(posedge aclk) sclk_q <= sclk;
	always_ff @(posedge aclk) begin
		if (!aresetn || chip_select_n)
			first <= 1'b1;
		else if (sclk)
			first <= 1'b0;
	end
	// rising sclk edges within one select-low frame
	always_ff @(posedge aclk) begin
		if (!aresetn || chip_select_n)
			edges <= 6'h00;
		else if (sclk && !sclk_q)
			edges <= edges + 6'h01;
	end
	////////////////////////////////////////////////////////////////
	so_oe_off_a: assert property (chip_select_n [*4] |-> !so_oe)
		else $error("so driven while deselected");
	so_oe_on_a: assert property ($fell(chip_select_n) |-> ##[1:5] so_oe)
		else $error("so not driven after select");
	sclk_idle_a: assert property (chip_select_n |-> !sclk)
		else $error("sclk high while deselected");
	ready_wait_a: assert property ($rose(sclk) && first |-> !$past(so_line))
		else $error("first sclk edge while not ready");
	// phase lengths assume the default half period of 8 cycles
	high_phase_a: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
		else $error("sclk high phase length wrong");
	low_phase_a: assert property ($fell(sclk) |-> !sclk [*7])
		else $error("sclk low phase too short");
	si_hold_a: assert property (sclk && sclk_q |-> $stable(si))
		else $error("si changed while sclk high");
	byte_frame_a: assert property ($rose(chip_select_n) |-> edges[2:0] == 3'h0 && edges != 6'h00)
		else $error("frame not whole bytes");
endmodule
`default_nettype wire

// [test/spi_status_byte_reporter_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module spi_status_byte_reporter_tb_top
	import ssr_pkg::*;
;
	typedef struct packed {
		logic [2:0] st;
		logic [6:0] cnt;
		logic [7:0] hdr;
		logic [7:0] exp;
	} ssr_row_t;
	// the count of the other direction is 2, so a wrong count source shows
	localparam ssr_row_t ROWS [8] = '{
		'{3'h0, 7'h00, 8'h30, 8'h00}, '{3'h1, 7'h0e, 8'hbf, 8'h1e},
		'{3'h2, 7'h0f, 8'h3f, 8'h2f}, '{3'h3, 7'h10, 8'hff, 8'h3f},
		'{3'h4, 7'h7f, 8'h7f, 8'h4f}, '{3'h5, 7'h01, 8'h85, 8'h51},
		'{3'h6, 7'h07, 8'h3d, 8'h67}, '{3'h7, 7'h09, 8'h05, 8'h79}
	};
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic supply_ok = 1'b0, crystal_oscillator_ok = 1'b0;
	logic [2:0] main_state = 3'h0;
	logic [6:0] rx_count = 7'h00, tx_free = 7'h00;
	logic [7:0] rd_data = 8'h1d, awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [5:0] acc_addr, a_rd, a_wr;
	logic [7:0] wr_data, d_wr;
	logic wr_valid, rd_req, strobe_valid, chip_not_ready, others_powered_down;
	int err_count = 0, total_checks = 0, cyc = 0, n_stb = 0, n_rd = 0;
	ssr_if link_if ();
	ssr_host ssr_host_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .link(link_if), .irq(irq));
	ssr_device ssr_device_i (.aclk(aclk), .aresetn(aresetn), .link(link_if),
		.supply_ok(supply_ok), .crystal_oscillator_ok(crystal_oscillator_ok), .main_state(main_state),
		.rx_count(rx_count), .tx_free(tx_free), .rd_data(rd_data), .acc_addr(acc_addr),
		.wr_valid(wr_valid), .wr_data(wr_data), .rd_req(rd_req),
		.strobe_valid(strobe_valid), .chip_not_ready(chip_not_ready),
		.others_powered_down(others_powered_down));
	ssr_checker ssr_checker_i (.aclk(aclk), .aresetn(aresetn),
		.chip_select_n(link_if.chip_select_n), .sclk(link_if.sclk), .si(link_if.si),
		.so(link_if.so), .so_oe(link_if.so_oe), .so_line(link_if.so_line));
	initial forever #4 aclk = ~aclk;
	////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		if (err_count == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t register got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t pin got %h expected %h", $time, got, exp);
		end
	endtask
	// ready is sampled at the falling edge, where nothing driven here moves
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw, w, done;
		logic [1:0] r;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(negedge aclk);
			aw = awready;
			w = wready;
			done = bvalid;
			r = bresp;
			@(posedge aclk);
			if (aw === 1'b1)
				awvalid <= 1'b0;
			if (w === 1'b1)
				wvalid <= 1'b0;
			if (done === 1'b1)
				break;
		end
		bready <= 1'b0;
		chk_reg({30'h0, r}, {30'h0, er});
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar, done;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(negedge aclk);
			ar = arready;
			done = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (ar === 1'b1)
				arvalid <= 1'b0;
			if (done === 1'b1)
				break;
		end
		rready <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk_reg(d, e);
		chk_reg({30'h0, r}, {30'h0, er});
	endtask
	task automatic wait_idle();
		logic [31:0] d;
		logic [1:0] r;
		repeat (300) begin
			rd(REG_STAT, d, r);
			if (d[STAT_BUSY_BIT] === 1'b0)
				break;
		end
	endtask
	task automatic send(input logic [7:0] b, input logic keep, input logic st);
		wr(REG_TXN, {22'h0, st, keep, b}, RESP_OKAY);
		wait_idle();
	endtask
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			give_verdict();
		end
		if (strobe_valid === 1'b1)
			n_stb++;
		if (rd_req === 1'b1) begin
			n_rd++;
			a_rd = acc_addr;
		end
		if (wr_valid === 1'b1) begin
			a_wr = acc_addr;
			d_wr = wr_data;
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		int s, q;
		logic stb;
		logic [7:0] h;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rd_chk(REG_STAT, 32'h0ff, RESP_OKAY);
		chk_pin({7'h0, chip_not_ready}, 8'h01);
		wr(REG_TXN, {22'h002, HDR_TX_SINGLE}, RESP_OKAY);
		repeat (60) @(posedge aclk);
		supply_ok <= 1'b1;
		repeat (60) @(posedge aclk);
		rd_chk(REG_STAT, 32'h1ff, RESP_OKAY);
		wr(REG_TXN, {22'h200, HDR_TX_SINGLE}, RESP_SLVERR);
		crystal_oscillator_ok <= 1'b1;
		// the held transfer runs once ready falls; a new one is refused until it completes
		wait_idle();
		send(8'h00, 1'b0, 1'b0);
		rd_chk(REG_STAT, 32'h000, RESP_OKAY);
		chk_pin({7'h0, chip_not_ready}, 8'h00);
		for (int i = 0; i < 8; i++) begin
			s = n_stb;
			q = n_rd;
			h = ROWS[i].hdr;
			stb = h[7:6] == 2'b00 && h[5:0] >= STROBE_FIRST && h[5:0] <= STROBE_LAST;
			main_state <= ROWS[i].st;
			rx_count <= h[7] ? ROWS[i].cnt : 7'h02;
			tx_free <= h[7] ? 7'h02 : ROWS[i].cnt;
			send(h, 1'b0, 1'b1);
			rd_chk(REG_STAT, {24'h0, ROWS[i].exp}, RESP_OKAY);
			chk_pin(8'(n_stb - s), {7'h0, stb});
			chk_pin(8'(n_rd - q), {7'h0, h[7]});
			chk_pin({7'h0, others_powered_down}, {7'h0, ROWS[i].st == 3'h0});
		end
		rd_chk(REG_IRQ_STAT, 32'h7, RESP_OKAY);
		chk_pin({7'h0, irq}, 8'h00);
		wr(REG_IRQ_EN, 32'h2, RESP_OKAY);
		chk_pin({7'h0, irq}, 8'h01);
		wr(REG_IRQ_CLR, 32'h2, RESP_OKAY);
		chk_pin({7'h0, irq}, 8'h00);
		rd_chk(REG_IRQ_STAT, 32'h5, RESP_OKAY);
		rd_chk(8'h40, 32'h0, RESP_SLVERR);
		wr(8'h40, 32'h0, RESP_SLVERR);
		for (int k = 0; k < 2; k++) begin
			h = k ? HDR_TX_BURST : 8'h42;
			send(h, 1'b1, 1'b1);
			send(8'ha5, 1'b1, 1'b1);
			chk_pin({2'h0, a_wr}, {2'h0, h[5:0]});
			chk_pin(d_wr, 8'ha5);
			send(8'h5a, 1'b0, 1'b1);
			chk_pin({2'h0, a_wr}, {2'h0, k ? FIFO_ADDR : h[5:0] + 6'h01});
			chk_pin(d_wr, 8'h5a);
		end
		send(8'hc4, 1'b1, 1'b1);
		send(8'h00, 1'b0, 1'b0);
		rd_chk(REG_RXD, 32'h1d, RESP_OKAY);
		chk_pin({2'h0, a_rd}, 8'h05);
		wr(REG_IRQ_EN, 32'h7, RESP_OKAY);
		chk_pin({7'h0, irq}, 8'h01);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		chk_pin({6'h0, irq, chip_not_ready}, 8'h01);
		aresetn <= 1'b1;
		rd_chk(REG_STAT, 32'h0ff, RESP_OKAY);
		rd_chk(REG_IRQ_STAT, 32'h0, RESP_OKAY);
		chk_pin({7'h0, chip_not_ready}, 8'h00);
		give_verdict();
	end
endmodule
`default_nettype wire
